// >>> design/pcr_pkg.sv
package pcr_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int COEFF_W = 16;
  localparam int RESULT_W = 36;
  localparam int HIST_W = 17;
  localparam int MODE_W = 3;

  // ----------------------------------------------------------------
  // register indices, one byte register per index
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_COEFF_HIGH = 4'h1;
  localparam logic [3:0] IDX_COEFF_LOW = 4'h2;
  localparam logic [3:0] IDX_RES_UPPER = 4'h3;
  localparam logic [3:0] IDX_RES_HH = 4'h4;
  localparam logic [3:0] IDX_RES_HL = 4'h5;
  localparam logic [3:0] IDX_RES_LH = 4'h6;
  localparam logic [3:0] IDX_RES_LL = 4'h7;
  localparam logic [3:0] IDX_ERRA_UPPER = 4'h8;
  localparam logic [3:0] IDX_ERRA_HIGH = 4'h9;
  localparam logic [3:0] IDX_ERRA_LOW = 4'hA;
  localparam logic [3:0] IDX_ERRB_UPPER = 4'hB;
  localparam logic [3:0] IDX_ERRB_HIGH = 4'hC;
  localparam logic [3:0] IDX_ERRB_LOW = 4'hD;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_BUSY_BIT = 6;
  localparam int CTRL_MODE_LSB = 0;
  localparam logic [2:0] MODE_PID = 3'h5;

  // ----------------------------------------------------------------
  // implemented-bit masks of the partial upper bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] RES_UPPER_MASK = 8'h0F;
  localparam logic [7:0] HIST_UPPER_MASK = 8'h01;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COEFF = 16'h0000;
  localparam logic [35:0] RST_RESULT = 36'h000000000;
  localparam logic [16:0] RST_HIST = 17'h00000;
  localparam logic [2:0] RST_MODE = 3'h0;

  // ----------------------------------------------------------------
  // calculation sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCR_IDLE = 2'b01,
    PCR_CALC = 2'b10
  } pcr_state_e;

endpackage : pcr_pkg

// >>> design/pcr_regs.sv
module pcr_regs (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // software register port
  input wire logic [pcr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pcr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pcr_pkg::DATA_W-1:0] reg_rdata,
  // datapath side
  input wire logic calc_start,
  input wire logic calc_done,
  input wire logic [pcr_pkg::RESULT_W-1:0] calc_result,
  input wire logic [pcr_pkg::HIST_W-1:0] calc_error,
  // settings seen by the datapath
  output logic [pcr_pkg::COEFF_W-1:0] derivative_coefficient,
  output logic [pcr_pkg::MODE_W-1:0] calc_mode,
  output logic calc_enable,
  output logic busy
);
  import pcr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    pcr_state_e state;
    logic enable;
    logic [MODE_W-1:0] mode;
    logic busy;
    logic [COEFF_W-1:0] coeff;
    logic [RESULT_W-1:0] result;
    logic [HIST_W-1:0] prior_error_a;
    logic [HIST_W-1:0] prior_error_b;
    logic [DATA_W-1:0] rdata;
  } pcr_state_s;

  pcr_state_s st;
  pcr_state_s next_st;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte view of one register, unimplemented bits forced to zero
  function automatic logic [7:0] read_byte(input pcr_state_s s, input logic [3:0] a);
    logic [7:0] ctl;
    ctl = 8'h00;
    ctl[CTRL_EN_BIT] = s.enable;
    ctl[CTRL_BUSY_BIT] = s.busy;
    ctl[CTRL_MODE_LSB +: MODE_W] = s.mode;
    unique case (a)
      IDX_CTRL: read_byte = ctl;
      IDX_COEFF_HIGH: read_byte = s.coeff[15:8];
      IDX_COEFF_LOW: read_byte = s.coeff[7:0];
      IDX_RES_UPPER: read_byte = {4'h0, s.result[35:32]};
      IDX_RES_HH: read_byte = s.result[31:24];
      IDX_RES_HL: read_byte = s.result[23:16];
      IDX_RES_LH: read_byte = s.result[15:8];
      IDX_RES_LL: read_byte = s.result[7:0];
      IDX_ERRA_UPPER: read_byte = {7'h00, s.prior_error_a[16]};
      IDX_ERRA_HIGH: read_byte = s.prior_error_a[15:8];
      IDX_ERRA_LOW: read_byte = s.prior_error_a[7:0];
      IDX_ERRB_UPPER: read_byte = {7'h00, s.prior_error_b[16]};
      IDX_ERRB_HIGH: read_byte = s.prior_error_b[15:8];
      IDX_ERRB_LOW: read_byte = s.prior_error_b[7:0];
      default: read_byte = RST_BYTE;
    endcase
  endfunction : read_byte

  // true when a write strobe targets the given index
  function automatic logic wr_hit(input logic wr, input logic [3:0] a, input logic [3:0] idx);
    wr_hit = wr && (a == idx);
  endfunction : wr_hit

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // read data stand for one cycle only, unmapped reads give zero
    next_st.rdata = reg_rd ? read_byte(st, reg_addr) : RST_BYTE;

    // control byte; busy is status only
    if (wr_hit(reg_wr, reg_addr, IDX_CTRL)) begin
      next_st.enable = reg_wdata[CTRL_EN_BIT];
      next_st.mode = reg_wdata[CTRL_MODE_LSB +: MODE_W];
    end

    if (wr_hit(reg_wr, reg_addr, IDX_COEFF_HIGH)) begin
      next_st.coeff[15:8] = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, IDX_COEFF_LOW)) begin
      next_st.coeff[7:0] = reg_wdata;
    end

    if (wr_hit(reg_wr, reg_addr, IDX_RES_UPPER)) begin
      next_st.result[35:32] = reg_wdata[3:0] & RES_UPPER_MASK[3:0];
    end
    if (wr_hit(reg_wr, reg_addr, IDX_RES_HH)) begin
      next_st.result[31:24] = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, IDX_RES_HL)) begin
      next_st.result[23:16] = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, IDX_RES_LH)) begin
      next_st.result[15:8] = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, IDX_RES_LL)) begin
      next_st.result[7:0] = reg_wdata;
    end

    if (wr_hit(reg_wr, reg_addr, IDX_ERRA_UPPER)) begin
      next_st.prior_error_a[16] = reg_wdata[0] & HIST_UPPER_MASK[0];
    end
    if (wr_hit(reg_wr, reg_addr, IDX_ERRA_HIGH)) begin
      next_st.prior_error_a[15:8] = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, IDX_ERRA_LOW)) begin
      next_st.prior_error_a[7:0] = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, IDX_ERRB_UPPER)) begin
      next_st.prior_error_b[16] = reg_wdata[0] & HIST_UPPER_MASK[0];
    end
    if (wr_hit(reg_wr, reg_addr, IDX_ERRB_HIGH)) begin
      next_st.prior_error_b[15:8] = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, IDX_ERRB_LOW)) begin
      next_st.prior_error_b[7:0] = reg_wdata;
    end

    // datapath stores come last so a finishing calculation beats a
    // software write to the same byte; the result must not be torn
    if (calc_done) begin
      next_st.result = calc_result;
      if (st.mode == MODE_PID) begin
        next_st.prior_error_a = calc_error;
        next_st.prior_error_b = st.prior_error_a;
      end
    end

    // busy sequencer; a start in the done cycle keeps busy up
    unique case (st.state)
      PCR_IDLE: begin
        if (calc_start && st.enable) begin
          next_st.state = PCR_CALC;
          next_st.busy = 1'b1;
        end
      end
      PCR_CALC: begin
        if (calc_done && !(calc_start && st.enable)) begin
          next_st.state = PCR_IDLE;
          next_st.busy = 1'b0;
        end
      end
      default: begin
        next_st.state = PCR_IDLE;
        next_st.busy = 1'b0;
      end
    endcase

    // disabling the unit abandons a calculation in flight
    if (!next_st.enable) begin
      next_st.state = PCR_IDLE;
      next_st.busy = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // every field clears on reset except the sequencer state, which loads PCR_IDLE
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st.state <= PCR_IDLE;
      st.enable <= 1'b0;
      st.mode <= RST_MODE;
      st.busy <= 1'b0;
      st.coeff <= RST_COEFF;
      st.result <= RST_RESULT;
      st.prior_error_a <= RST_HIST;
      st.prior_error_b <= RST_HIST;
      st.rdata <= RST_BYTE;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign reg_rdata = st.rdata;
  assign derivative_coefficient = st.coeff;
  assign calc_mode = st.mode;
  assign calc_enable = st.enable;
  assign busy = st.busy;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_coeff_high_write;
    @(posedge clk_sys) disable iff (rst)
      (ce && reg_wr && reg_addr == IDX_COEFF_HIGH) |=>
        derivative_coefficient[15:8] == $past(reg_wdata);
  endproperty
  a_coeff_high_write: assert property (p_coeff_high_write)
    else $error("coefficient high byte not stored");

  property p_result_store;
    @(posedge clk_sys) disable iff (rst)
      (ce && calc_done) |=> st.result == $past(calc_result);
  endproperty
  a_result_store: assert property (p_result_store)
    else $error("result not stored on done");

  property p_res_upper_read;
    @(posedge clk_sys) disable iff (rst)
      (ce && reg_rd && reg_addr == IDX_RES_UPPER) |=>
        reg_rdata == {4'h0, $past(st.result[35:32])};
  endproperty
  a_res_upper_read: assert property (p_res_upper_read)
    else $error("upper result byte reads wrong");

  property p_hist_a_update;
    @(posedge clk_sys) disable iff (rst)
      (ce && calc_done && calc_mode == MODE_PID) |=> st.prior_error_a == $past(calc_error);
  endproperty
  a_hist_a_update: assert property (p_hist_a_update)
    else $error("first history store not updated");

  property p_hist_b_update;
    @(posedge clk_sys) disable iff (rst)
      (ce && calc_done && calc_mode == MODE_PID) |=>
        st.prior_error_b == $past(st.prior_error_a);
  endproperty
  a_hist_b_update: assert property (p_hist_b_update)
    else $error("second history store not shifted");

  property p_hist_upper_read;
    @(posedge clk_sys) disable iff (rst)
      (ce && reg_rd && (reg_addr == IDX_ERRA_UPPER || reg_addr == IDX_ERRB_UPPER)) |=>
        reg_rdata[7:1] == 7'h00;
  endproperty
  a_hist_upper_read: assert property (p_hist_upper_read)
    else $error("history upper byte has stray bits");

  property p_coeff_low_readback;
    @(posedge clk_sys) disable iff (rst)
      (ce && reg_rd && reg_addr == IDX_COEFF_LOW) |=>
        reg_rdata == $past(derivative_coefficient[7:0]) ##1 (!$past(ce) || reg_rdata == 8'h00 ||
        $past(reg_rd));
  endproperty
  a_coeff_low_readback: assert property (p_coeff_low_readback)
    else $error("coefficient low byte readback wrong");

  property p_hist_hold_other_mode;
    @(posedge clk_sys) disable iff (rst)
      (ce && calc_done && calc_mode != MODE_PID && !reg_wr) |=>
        $stable(st.prior_error_a) && $stable(st.prior_error_b);
  endproperty
  a_hist_hold_other_mode: assert property (p_hist_hold_other_mode)
    else $error("history moved outside PID mode");

  property p_busy_rise;
    @(posedge clk_sys) disable iff (rst)
      (ce && !busy && calc_start && calc_enable && !(reg_wr && reg_addr == IDX_CTRL)) |=>
        busy;
  endproperty
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy did not rise on start");

  property p_busy_fall;
    @(posedge clk_sys) disable iff (rst)
      (ce && busy && calc_done && !calc_start) |=> !busy;
  endproperty
  a_busy_fall: assert property (p_busy_fall)
    else $error("busy did not fall on done");

  property p_coeff_low_write;
    @(posedge clk_sys) disable iff (rst)
      (ce && reg_wr && reg_addr == IDX_COEFF_LOW) |=>
        derivative_coefficient[7:0] == $past(reg_wdata);
  endproperty
  a_coeff_low_write: assert property (p_coeff_low_write)
    else $error("coefficient low byte not stored");

  property p_res_upper_write;
    @(posedge clk_sys) disable iff (rst)
      (ce && reg_wr && reg_addr == IDX_RES_UPPER && !calc_done) |=>
        st.result[35:32] == $past(reg_wdata[3:0]);
  endproperty
  a_res_upper_write: assert property (p_res_upper_write)
    else $error("upper result nibble not stored");

  property p_hist_upper_write;
    @(posedge clk_sys) disable iff (rst)
      (ce && reg_wr && reg_addr == IDX_ERRA_UPPER && !calc_done) |=>
        st.prior_error_a[16] == $past(reg_wdata[0]);
  endproperty
  a_hist_upper_write: assert property (p_hist_upper_write)
    else $error("history bit 16 not stored");

  // read data must not linger past their one cycle
  property p_rdata_idle;
    @(posedge clk_sys) disable iff (rst)
      (ce && !reg_rd) |=> reg_rdata == RST_BYTE;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data left standing");

  property p_reset_clear;
    @(posedge clk_sys) rst |=>
      reg_rdata == RST_BYTE && !busy && !calc_enable && derivative_coefficient == RST_COEFF;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("outputs not cleared by reset");

  c_pid_update: cover property (@(posedge clk_sys) disable iff (rst)
    ce && calc_done && calc_mode == MODE_PID);
  c_busy_cycle: cover property (@(posedge clk_sys) disable iff (rst)
    ce && busy ##1 ce && !busy);
  c_back_to_back: cover property (@(posedge clk_sys) disable iff (rst)
    ce && calc_done && calc_start && calc_enable);
  c_done_beats_write: cover property (@(posedge clk_sys) disable iff (rst)
    ce && calc_done && reg_wr && reg_addr == IDX_RES_LL);

endmodule : pcr_regs

// >>> verification/pcr_regs_tb.sv
`define CHK(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) begin \
      bad_count++; \
      $display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end

module pcr_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pcr_pkg::*;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_sys, rst, ce, reg_wr, reg_rd, calc_start, calc_done, calc_enable, busy;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [35:0] calc_result;
  logic [16:0] calc_error;
  logic [15:0] derivative_coefficient;
  logic [2:0] calc_mode;
  int bad_count = 0;
  int checks_done = 0;
  // reference copy of what software should see
  logic [15:0] m_coeff = 16'h0000;
  logic [35:0] m_res = 36'h000000000;
  logic [16:0] m_a = 17'h00000;
  logic [16:0] m_b = 17'h00000;
  logic [7:0] m_ctrl = 8'h00;

  pcr_regs dut_u (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .calc_start(calc_start),
    .calc_done(calc_done), .calc_result(calc_result), .calc_error(calc_error),
    .derivative_coefficient(derivative_coefficient), .calc_mode(calc_mode),
    .calc_enable(calc_enable), .busy(busy)
  );

  // ----------------------------------------------------------------
  // clock, 5 ns period
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // bus tasks and reference lookup
  // ----------------------------------------------------------------
  // unmapped and partial bytes read as zero above their implemented bits
  function automatic logic [7:0] exp_byte(input logic [3:0] idx);
    case (idx)
      IDX_COEFF_HIGH: return m_coeff[15:8];
      IDX_COEFF_LOW: return m_coeff[7:0];
      IDX_RES_UPPER: return {4'h0, m_res[35:32]};
      IDX_RES_HH: return m_res[31:24];
      IDX_RES_HL: return m_res[23:16];
      IDX_RES_LH: return m_res[15:8];
      IDX_RES_LL: return m_res[7:0];
      IDX_ERRA_UPPER: return {7'h00, m_a[16]};
      IDX_ERRA_HIGH: return m_a[15:8];
      IDX_ERRA_LOW: return m_a[7:0];
      IDX_ERRB_UPPER: return {7'h00, m_b[16]};
      IDX_ERRB_HIGH: return m_b[15:8];
      IDX_ERRB_LOW: return m_b[7:0];
      default: return 8'h00;
    endcase
  endfunction : exp_byte

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] ex);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", ex, reg_rdata)
  endtask : rd

  task automatic check_all();
    for (int i = 1; i < 16; i++) begin
      rd(4'(i), exp_byte(4'(i)));
    end
  endtask : check_all

  // start, watch busy through the register, then finish with result and error
  task automatic calc(input logic [35:0] res, input logic [16:0] err, input logic pid);
    @(posedge clk_sys);
    calc_start <= 1'b1;
    @(posedge clk_sys);
    calc_start <= 1'b0;
    #1;
    `CHK("busy_rise", 1'b1, busy)
    rd(IDX_CTRL, m_ctrl | (8'h01 << CTRL_BUSY_BIT));
    @(posedge clk_sys);
    calc_done <= 1'b1;
    calc_result <= res;
    calc_error <= err;
    @(posedge clk_sys);
    calc_done <= 1'b0;
    #1;
    `CHK("busy_fall", 1'b0, busy)
    m_res = res;
    if (pid) begin
      m_b = m_a;
      m_a = err;
    end
    check_all();
  endtask : calc

  task automatic finish_test();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // watchdog: the sequence needs well under 2000 cycles
  // ----------------------------------------------------------------
  initial begin
    #50000;
    bad_count++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    calc_start = 1'b0;
    calc_done = 1'b0;
    calc_result = 36'h000000000;
    calc_error = 17'h00000;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    check_all(); // every byte but control clears on reset
    rd(IDX_CTRL, 8'h00); // control idle after reset
    // all ones in every byte but control shows which bits exist
    for (int i = 1; i < 16; i++) begin
      wr(4'(i), 8'hFF);
    end
    m_coeff = 16'hFFFF;
    m_res = {36{1'b1}};
    m_a = 17'h1FFFF;
    m_b = 17'h1FFFF;
    check_all(); // partial upper bytes masked
    wr(IDX_COEFF_HIGH, 8'hA5);
    wr(IDX_COEFF_LOW, 8'h3C);
    #1;
    m_coeff = 16'hA53C;
    `CHK("coeff_out", 16'hA53C, derivative_coefficient) // both bytes reach datapath
    rd(IDX_COEFF_HIGH, 8'hA5); // high byte readback
    // a frozen clock enable must swallow the write
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(IDX_COEFF_LOW, 8'h11);
    ce <= 1'b1;
    #1;
    `CHK("coeff_frozen", 16'hA53C, derivative_coefficient) // held while frozen
    // a start while disabled is dropped
    @(posedge clk_sys);
    calc_start <= 1'b1;
    @(posedge clk_sys);
    calc_start <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK("busy_off", 1'b0, busy) // no busy without enable
    wr(IDX_CTRL, 8'hFD);
    #1;
    m_ctrl = 8'h85;
    `CHK("mode_out", MODE_PID, calc_mode) // PID mode code
    `CHK("enable_out", 1'b1, calc_enable) // enable bit reaches datapath
    rd(IDX_CTRL, 8'h85); // busy and spare bits ignore writes
    calc(36'hA12345678, 17'h1ABCD, 1'b1); // result and first shift
    calc(36'h5DEADBEEF, 17'h01357, 1'b1); // newest error pushes older down
    wr(IDX_CTRL, 8'h81);
    m_ctrl = 8'h81;
    calc(36'h0CAFE0042, 17'h10F0F, 1'b0); // history frozen outside PID
    // second reset in mid-run
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    m_coeff = 16'h0000;
    m_res = 36'h000000000;
    m_a = 17'h00000;
    m_b = 17'h00000;
    `CHK("coeff_rst", 16'h0000, derivative_coefficient) // coefficient clears
    `CHK("enable_rst", 1'b0, calc_enable) // enable clears
    check_all(); // all bytes but control clear again
    rd(IDX_CTRL, 8'h00); // control clears
    finish_test();
  end
endmodule : pcr_regs_tb
